// ===== logic/pwi_pkg.sv
// shared constants, register map, interval layout and state types of the waveform engine
package pwi_pkg;

   // ------------------------------------------------------------
   // register map (byte addresses, 8-bit data)
   // ------------------------------------------------------------
   localparam logic [15:0] REG_IFCFG = 16'h7824;
   localparam logic [15:0] REG_OUTCFG = 16'h7825;
   localparam logic [15:0] REG_READY = 16'h7826;
   localparam logic [15:0] REG_IDLECS = 16'h7827;
   localparam logic [15:0] REG_IDLEOUT = 16'h7828;
   localparam logic [15:0] REG_ADDR = 16'h7829;
   localparam logic [15:0] REG_COUNT = 16'h782a;
   localparam logic [15:0] REG_WDLO = 16'h782b;
   localparam logic [15:0] REG_WDHI = 16'h782c;
   localparam logic [15:0] REG_RDLO = 16'h782d;
   localparam logic [15:0] REG_RDHI = 16'h782e;
   localparam logic [15:0] REG_TRIG = 16'h782f;
   localparam logic [15:0] WMEM_BASE = 16'h7900;
   localparam logic [15:0] WMEM_LAST = 16'h797f;

   // ------------------------------------------------------------
   // register fields
   // ------------------------------------------------------------
   localparam int unsigned WIDE_BIT = 2;
   localparam int unsigned TRI_BIT = 7;
   localparam int unsigned SYNC_BIT = 6;
   localparam int unsigned DONE_BIT = 7;
   localparam int unsigned IDLE_DRV_BIT = 0;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] IDLEOUT_RST = 8'h00;
   localparam logic [5:0] OD_RST = 6'h00;
   localparam logic [7:0] COUNT_RST = 8'h01;

   // ------------------------------------------------------------
   // interval word layout
   // ------------------------------------------------------------
   localparam int unsigned IV_LEN_LSB = 0;
   localparam int unsigned IV_OUT_LSB = 8;
   localparam int unsigned IV_OE_LSB = 12;
   localparam int unsigned IV_DATA_BIT = 16;
   localparam int unsigned IV_AINC_BIT = 17;
   localparam int unsigned IV_DP_BIT = 18;
   localparam int unsigned IV_RSEL_LSB = 24;
   localparam int unsigned IV_TGT_LSB = 27;
   localparam int unsigned IV_LVL_BIT = 30;
   localparam logic [2:0] IV_IDLE = 3'h7;
   localparam int unsigned NUM_PROG = 4;
   localparam int unsigned NUM_IV = 8;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      PWI_IDLE = 2'b00,
      PWI_FETCH = 2'b01,
      PWI_EXEC = 2'b11
   } pwi_state_e;

   typedef struct packed {
      logic [5:0] strobe_out;
      logic [5:0] strobe_oe;
      logic [5:0] addr_out;
      logic [7:0] data_low_lane_out;
      logic data_low_lane_oe;
      logic [7:0] data_high_lane_out;
      logic data_high_lane_oe;
   } pwi_pins_s;

   typedef struct packed {
      logic wide_bus_select;
      logic tristate_control_mode;
      logic [5:0] strobe_output_config;
      logic ready_sync_select;
      logic idle_bus_drive;
      logic [7:0] idle_strobe;
      logic [5:0] addr;
      logic [7:0] count;
      logic [7:0] wd_lo;
      logic [7:0] wd_hi;
      logic [7:0] rd_lo;
      logic [7:0] rd_hi;
      pwi_state_e st;
      logic [1:0] prog;
      logic [2:0] iv;
      logic [7:0] cnt;
      logic ext_sel;
      logic strap_taken;
      logic ext_prev;
      logic [5:0] rdy1;
      logic [5:0] rdy2;
      logic [7:0] rdata;
      pwi_pins_s pins;
   } pwi_state_s;

   // returns {oe, out} for the six strobes
   function automatic logic [11:0] pwi_strobe_drive(input logic [5:0] v, input logic [3:0] en,
                                                    input logic tri_mode, input logic [5:0] od);
      logic [5:0] oe;
      logic [5:0] o;
      oe = '0;
      o = v;
      for (int i = 0; i < 6; i++) begin
         if (tri_mode) begin
            if (i < 4) begin
               oe[i] = en[i];
            end else begin
               oe[i] = 1'b1;
               o[i] = 1'b0;
            end
         end else if (od[i]) begin
            oe[i] = ~v[i];
            o[i] = 1'b0;
         end else begin
            oe[i] = 1'b1;
         end
      end
      return {oe, o};
   endfunction

endpackage

// ===== logic/pwi_wave_mem.sv
// waveform memory: byte-wide software writes, registered word reads for the engine
`timescale 1ns/1ps
module pwi_wave_mem #(
   parameter int unsigned WORDS = 32
) (
   input wire logic clk, // engine clock
   input wire logic wr_en, // byte write strobe
   input wire logic [$clog2(WORDS*4)-1:0] wr_addr, // byte address
   input wire logic [7:0] wr_byte, // byte to store
   input wire logic [$clog2(WORDS)-1:0] rd_idx, // word index
   output logic [31:0] rd_data // word, one cycle after rd_idx
);

   initial begin
      if (WORDS < 2 || (WORDS & (WORDS - 1)) != 0) begin
         $error("pwi_wave_mem: WORDS must be a power of two");
      end
   end

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [3:0][7:0] mem [WORDS];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr[$clog2(WORDS*4)-1:2]][wr_addr[1:0]] <= wr_byte;
      end
      rd_data <= mem[rd_idx];
   end

endmodule

// ===== logic/pwi_engine.sv
// parallel waveform engine: pins, configuration registers and interval sequencer
//
// Function
// - six strobes, six readies, six address lines, low and high data lanes
// - narrow bus uses low lane only; wide bus uses both lanes
// - address increments per transfer in bursts, holds otherwise
// - strap high selects external clock pin, else internal clock
// - wide-bus select bit 2 picks 16-bit or 8-bit data bus
// - strobes 0-3 drive, open-drain or tristate
// - strobes 4-5 drive or open-drain, never tristated
// - in tristate mode strobes 4-5 are withheld from the engine
// - tristate mode: 0/1/z; else config bit 1 open-drain, 0 driven
// - twelve config and status locations in processor data space
// - 128-byte writable waveform memory region
// - four programs of up to seven 32-bit intervals
// - ready inputs stall, continue or repeat a transaction
// - ready-sync bit 6: one sample when 1, two samples when 0
// - every waveform ends by branching to idle interval 7
// - done bit 7 reads 0 while running, 1 when idle
// - idle bus-drive bit 0 holds last value, else lanes float
`timescale 1ns/1ps
module pwi_engine
   import pwi_pkg::*;
#(
   parameter int unsigned ADDR_W = 6
) (
   input wire logic clk, // system clock, also the internal engine clock
   input wire logic rstn, // asynchronous reset, active low
   input wire logic [15:0] reg_addr, // register byte address
   input wire logic [7:0] reg_wdata, // register write data
   input wire logic reg_we, // write strobe
   input wire logic reg_re, // read strobe
   output logic [7:0] reg_rdata, // read data, cycle after reg_re
   input wire logic external_clock_pin, // external engine clock
   input wire logic clock_source_strap, // high selects external clock
   input wire logic [5:0] ready_in, // ready inputs from the peripheral
   input wire logic [7:0] data_low_lane_in, // low lane level
   input wire logic [7:0] data_high_lane_in, // high lane level
   output pwi_pins_s pins // strobes, address and data lane drives
);

   initial begin
      if (ADDR_W != 6) begin
         $error("pwi_engine: ADDR_W must be 6");
      end
   end

   // ------------------------------------------------------------
   // state and waveform memory
   // ------------------------------------------------------------
   pwi_state_s s;
   pwi_state_s next_s;
   logic [31:0] ins;
   logic mem_wr;
   logic tick;
   logic leave;
   logic [2:0] dest;
   logic [5:0] rdy_pick;
   logic [11:0] drv;
   logic done;
   logic is_write;
   logic is_burst;

   assign mem_wr = reg_we && reg_addr >= WMEM_BASE && reg_addr <= WMEM_LAST;
   assign done = (s.st == PWI_IDLE);
   assign is_write = ~s.prog[0];
   assign is_burst = s.prog[1];
   // internal clock advances every cycle; external one on each sampled rising edge
   assign tick = s.ext_sel ? (external_clock_pin & ~s.ext_prev) : 1'b1;
   assign rdy_pick = s.ready_sync_select ? s.rdy1 : s.rdy2;

   pwi_wave_mem #(
      .WORDS(NUM_PROG * NUM_IV)
   ) u_mem (
      .clk(clk),
      .wr_en(mem_wr),
      .wr_addr(reg_addr[6:0]),
      .wr_byte(reg_wdata),
      .rd_idx({s.prog, s.iv}),
      .rd_data(ins)
   );

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_s = s;
      leave = 1'b0;
      dest = IV_IDLE;
      drv = '0;
      next_s.rdata = 8'h00;
      next_s.ext_prev = external_clock_pin;
      // strap is caught once, on the first edge after reset release
      if (!s.strap_taken) begin
         next_s.ext_sel = clock_source_strap;
         next_s.strap_taken = 1'b1;
      end
      if (tick) begin
         next_s.rdy1 = ready_in;
         next_s.rdy2 = s.rdy1;
      end

      // register writes
      if (reg_we) begin
         case (reg_addr)
            REG_IFCFG: begin
               next_s.wide_bus_select = reg_wdata[WIDE_BIT];
            end
            REG_OUTCFG: begin
               next_s.tristate_control_mode = reg_wdata[TRI_BIT];
               next_s.strobe_output_config = reg_wdata[5:0];
            end
            REG_READY: begin
               next_s.ready_sync_select = reg_wdata[SYNC_BIT];
            end
            REG_IDLECS: begin
               next_s.idle_bus_drive = reg_wdata[IDLE_DRV_BIT];
            end
            REG_IDLEOUT: begin
               next_s.idle_strobe = reg_wdata;
            end
            REG_ADDR: begin
               next_s.addr = reg_wdata[5:0];
            end
            REG_COUNT: begin
               next_s.count = reg_wdata;
            end
            REG_WDLO: begin
               next_s.wd_lo = reg_wdata;
            end
            REG_WDHI: begin
               next_s.wd_hi = reg_wdata;
            end
            REG_TRIG: begin
               // a trigger while busy is dropped; software must wait for done
               if (done && s.strap_taken) begin
                  next_s.prog = reg_wdata[1:0];
                  next_s.iv = 3'h0;
                  next_s.cnt = 8'h00;
                  next_s.st = PWI_FETCH;
               end
            end
            default: begin
            end
         endcase
      end

      // register reads, answered in the following cycle only
      if (reg_re) begin
         case (reg_addr)
            REG_IFCFG: next_s.rdata = {5'h00, s.wide_bus_select, 2'h0};
            REG_OUTCFG: next_s.rdata = {s.tristate_control_mode, 1'b0, s.strobe_output_config};
            REG_READY: next_s.rdata = {1'b0, s.ready_sync_select, s.rdy1};
            REG_IDLECS: next_s.rdata = {done, 6'h00, s.idle_bus_drive};
            REG_IDLEOUT: next_s.rdata = s.idle_strobe;
            REG_ADDR: next_s.rdata = {2'h0, s.addr};
            REG_COUNT: next_s.rdata = s.count;
            REG_WDLO: next_s.rdata = s.wd_lo;
            REG_WDHI: next_s.rdata = s.wd_hi;
            REG_RDLO: next_s.rdata = s.rd_lo;
            REG_RDHI: next_s.rdata = s.rd_hi;
            REG_TRIG: next_s.rdata = {done, 5'h00, s.prog};
            default: next_s.rdata = 8'h00;
         endcase
      end

      // interval sequencer
      case (s.st)
         PWI_IDLE: begin
         end
         PWI_FETCH: begin
            next_s.st = PWI_EXEC;
         end
         PWI_EXEC: begin
            if (tick) begin
               if (ins[IV_DP_BIT]) begin
                  // decision point waits until the chosen ready matches
                  leave = (rdy_pick[ins[IV_RSEL_LSB +: 3]] == ins[IV_LVL_BIT]);
                  dest = ins[IV_TGT_LSB +: 3];
               end else begin
                  leave = (s.cnt == ins[IV_LEN_LSB +: 8]);
                  dest = s.iv + 3'h1;
               end
               if (!leave) begin
                  if (!ins[IV_DP_BIT]) begin
                     next_s.cnt = s.cnt + 8'h01;
                  end
               end else begin
                  next_s.cnt = 8'h00;
                  if (ins[IV_DATA_BIT] && !is_write) begin
                     next_s.rd_lo = data_low_lane_in;
                     next_s.rd_hi = s.wide_bus_select ? data_high_lane_in : 8'h00;
                  end
                  if (ins[IV_DATA_BIT] && ins[IV_AINC_BIT] && is_burst) begin
                     next_s.addr = s.addr + 6'h01;
                  end
                  if (dest == IV_IDLE) begin
                     // burst programs rerun until the transfer count is used up
                     if (is_burst && s.count > 8'h01) begin
                        next_s.count = s.count - 8'h01;
                        next_s.iv = 3'h0;
                        next_s.st = PWI_FETCH;
                     end else begin
                        next_s.st = PWI_IDLE;
                     end
                  end else begin
                     next_s.iv = dest;
                     next_s.st = PWI_FETCH;
                  end
               end
            end
         end
         default: begin
            next_s.st = PWI_IDLE;
         end
      endcase

      // pin drives, registered; strobes and data lanes hold steady through a fetch, address follows addr
      next_s.pins.addr_out = s.addr;
      if (s.st == PWI_EXEC) begin
         drv = pwi_strobe_drive(ins[IV_OUT_LSB +: 6], ins[IV_OE_LSB +: 4],
                                s.tristate_control_mode, s.strobe_output_config);
         next_s.pins.strobe_out = drv[5:0];
         next_s.pins.strobe_oe = drv[11:6];
         if (ins[IV_DATA_BIT] && is_write) begin
            next_s.pins.data_low_lane_out = s.wd_lo;
            next_s.pins.data_low_lane_oe = 1'b1;
            next_s.pins.data_high_lane_out = s.wd_hi;
            next_s.pins.data_high_lane_oe = s.wide_bus_select;
         end else begin
            next_s.pins.data_low_lane_oe = 1'b0;
            next_s.pins.data_high_lane_oe = 1'b0;
         end
      end else if (s.st == PWI_IDLE) begin
         drv = pwi_strobe_drive(s.idle_strobe[5:0], s.idle_strobe[7:4],
                                s.tristate_control_mode, s.strobe_output_config);
         next_s.pins.strobe_out = drv[5:0];
         next_s.pins.strobe_oe = drv[11:6];
         // out registers still hold the last value a waveform drove
         next_s.pins.data_low_lane_oe = s.idle_bus_drive;
         next_s.pins.data_high_lane_oe = s.idle_bus_drive & s.wide_bus_select;
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.st <= PWI_IDLE;
         s.strobe_output_config <= OD_RST;
         s.idle_strobe <= IDLEOUT_RST;
         s.count <= COUNT_RST;
      end else begin
         s <= next_s;
      end
   end

   assign reg_rdata = s.rdata;
   assign pins = s.pins;

endmodule

// ===== bench/pwi_engine_chk.sv
// assertion checker on the waveform engine ports
`timescale 1ns/1ps
module pwi_engine_chk
   import pwi_pkg::*;
#(
   parameter int unsigned ADDR_W = 6
) (
   input wire logic clk, // clock
   input wire logic rstn, // reset, active low
   input wire logic [15:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_we, // write strobe
   input wire logic reg_re, // read strobe
   input wire logic [7:0] reg_rdata, // read data
   input wire pwi_pins_s pins // pin drives
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic wide;
   logic tri_m;
   logic [5:0] od;
   logic [1:0] prog;
   logic [2:0] c_cnt;
   logic [2:0] a_cnt;
   // pins lag a config write by a few cycles, so judge only settled config
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wide <= 1'b0;
         tri_m <= 1'b0;
         od <= OD_RST;
         prog <= 2'h0;
         c_cnt <= 3'h4;
         a_cnt <= 3'h4;
      end else begin
         c_cnt <= (c_cnt != 3'h0) ? c_cnt - 3'h1 : 3'h0;
         a_cnt <= (a_cnt != 3'h0) ? a_cnt - 3'h1 : 3'h0;
         if (reg_we && reg_addr inside {REG_IFCFG, REG_OUTCFG, REG_IDLEOUT, REG_IDLECS}) begin
            c_cnt <= 3'h4;
         end
         if (reg_we && reg_addr == REG_ADDR) begin
            a_cnt <= 3'h4;
         end
         if (reg_we && reg_addr == REG_IFCFG) begin
            wide <= reg_wdata[WIDE_BIT];
         end
         if (reg_we && reg_addr == REG_OUTCFG) begin
            tri_m <= reg_wdata[TRI_BIT];
            od <= reg_wdata[5:0];
         end
         if (reg_we && reg_addr == REG_TRIG) begin
            prog <= reg_wdata[1:0];
         end
      end
   end
   AST_HI_LANE: assert property (
      (c_cnt == 3'h0 && !wide) |-> !pins.data_high_lane_oe) else $error("high lane driven");
   AST_TRI_HI: assert property (
      (c_cnt == 3'h0 && tri_m) |-> (pins.strobe_oe[5:4] == 2'b11 && pins.strobe_out[5:4] == 2'b00))
      else $error("strobes 4,5 not held low");
   AST_OD_LOW: assert property (
      (c_cnt == 3'h0 && !tri_m) |-> (pins.strobe_out & od) == 6'h00) else $error("open-drain high");
   AST_DRV_ON: assert property (
      (c_cnt == 3'h0 && !tri_m) |-> (pins.strobe_oe | od) == 6'h3f) else $error("driven strobe off");
   AST_RD_IDLE: assert property (
      !$past(reg_re) |-> reg_rdata == 8'h00) else $error("read data outside its cycle");
   AST_RD_UNMAP: assert property (
      ($past(reg_re) && $past(reg_addr) > REG_TRIG && $past(reg_addr) <= WMEM_LAST)
      |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
   AST_ADDR_HOLD: assert property (
      (a_cnt == 3'h0 && !prog[1]) |-> $stable(pins.addr_out)) else $error("address moved");
   AST_ADDR_STEP: assert property (
      (a_cnt == 3'h0 && $changed(pins.addr_out)) |-> pins.addr_out == $past(pins.addr_out) + 6'h01)
      else $error("address step not one");
   AST_DONE_BUSY: assert property (
      (reg_we && reg_addr == REG_TRIG) ##1 (reg_re && reg_addr == REG_IDLECS)
      |=> !reg_rdata[DONE_BIT]) else $error("done set while running");
endmodule

bind pwi_engine pwi_engine_chk #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rstn(rstn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
   .reg_rdata(reg_rdata), .pins(pins));

// ===== bench/pwi_periph.sv
// peripheral model: four-phase handshake on strobe 0 against ready 0
`timescale 1ns/1ps
module pwi_periph
   import pwi_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rstn, // reset, active low
   input wire pwi_pins_s pins, // engine drives
   input wire logic [2:0] dly, // ready delay
   input wire logic [15:0] rd_val, // data offered on reads
   output logic [5:0] ready_in, // ready lines
   output logic [7:0] lo_lev, // low lane level
   output logic [7:0] hi_lev, // high lane level
   output logic cap_ok, // capture pulse
   output logic [21:0] cap, // address, high, low
   output logic [3:0] lat // ready rise to strobe fall
);
   logic [2:0] cnt;
   logic [7:0] lo_last;
   logic [7:0] hi_last;
   logic rdy;
   logic stb;
   logic drv;
   assign stb = pins.strobe_oe[0] & pins.strobe_out[0];
   assign drv = stb & ~pins.data_low_lane_oe;
   // a released lane shows rd_val while strobe 0 is high and the low lane is released, else the inverse of its last level, never a stale copy
   assign lo_lev = pins.data_low_lane_oe ? pins.data_low_lane_out : (drv ? rd_val[7:0] : ~lo_last);
   assign hi_lev = pins.data_high_lane_oe ? pins.data_high_lane_out :
      (drv ? rd_val[15:8] : ~hi_last);
   assign ready_in = {5'h00, rdy};
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 3'h0;
         rdy <= 1'b0;
         cap_ok <= 1'b0;
         cap <= '0;
         lat <= 4'h0;
         lo_last <= 8'h00;
         hi_last <= 8'h00;
      end else begin
         lo_last <= lo_lev;
         hi_last <= hi_lev;
         cap_ok <= 1'b0;
         if (rdy && stb) begin
            lat <= lat + 4'h1;
         end
         if (stb != rdy) begin
            cnt <= cnt + 3'h1;
            if (cnt >= dly) begin
               cnt <= 3'h0;
               rdy <= stb;
               cap_ok <= stb;
               // clear only when ready rises, so the count survives to the next check
               if (stb) lat <= 4'h0;
               cap <= {pins.addr_out, pins.data_high_lane_oe ? pins.data_high_lane_out : 8'h00,
                  lo_lev};
            end
         end
      end
   end
endmodule

// ===== bench/parallel_waveform_interface_test.sv
// self-checking bench: register port, strobe styles and waveform runs
`timescale 1ns/1ps
module parallel_waveform_interface_test;
   import pwi_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic reg_we = 1'b0;
   logic reg_re = 1'b0;
   logic re_seen = 1'b0;
   logic idrv = 1'b0;
   logic cap_ok;
   logic [15:0] reg_addr = '0;
   logic [15:0] rd_val = '0;
   logic [15:0] e;
   logic [7:0] reg_wdata = '0;
   logic [7:0] reg_rdata, lo_lev, hi_lev, rdv, wd_lo, wd_hi;
   logic [5:0] ready_in, base;
   logic [2:0] dly = '0;
   logic [3:0] lat, lat1;
   logic [21:0] cap;
   logic [63:0] pw;
   logic [27:0] sm[4] = '{28'h0014fd4, 28'h3f14ac0, 28'h805ad40, 28'h80f2fc2};
   pwi_pins_s pins;
   int num_errors = 0;
   int checks = 0;
   logic [15:0] rq[$];
   logic [21:0] cq[$];
   always #12.5 clk = ~clk;
   pwi_engine uut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .external_clock_pin(1'b0),
      .clock_source_strap(1'b0), .ready_in(ready_in), .data_low_lane_in(lo_lev),
      .data_high_lane_in(hi_lev), .pins(pins));
   pwi_periph peer (.clk(clk), .rstn(rstn), .pins(pins), .dly(dly), .rd_val(rd_val),
      .ready_in(ready_in), .lo_lev(lo_lev), .hi_lev(hi_lev), .cap_ok(cap_ok), .cap(cap), .lat(lat));
   task automatic note(input logic ok, input logic [21:0] g, input logic [21:0] x);
      checks++;
      if (!ok) begin
         num_errors++;
         $display("Error %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic cmp_reg(input logic [7:0] g, input logic [7:0] x);
      note(g === x, 22'(g), 22'(x));
   endtask
   task automatic cmp_cap(input logic [21:0] g, input logic [21:0] x);
      note(g === x, g, x);
   endtask
   task automatic cmp_pin(input logic [21:0] g, input logic [21:0] x);
      note(g === x, g, x);
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] v);
      @(posedge clk);
      reg_re <= 1'b1;
      reg_addr <= a;
      rq.push_back({m, v});
      @(posedge clk);
      reg_re <= 1'b0;
      #1 rdv = reg_rdata;
   endtask
   task automatic run(input logic [1:0] p);
      @(posedge clk);
      reg_we <= 1'b1;
      reg_addr <= REG_TRIG;
      reg_wdata <= {6'h00, p};
      @(posedge clk);
      reg_we <= 1'b0;
      reg_re <= 1'b1;
      reg_addr <= REG_IDLECS;
      rq.push_back({8'hff, 7'h00, idrv});
      @(posedge clk);
      reg_re <= 1'b0;
      // a second trigger while busy must leave the running burst alone
      if (p[1]) wr(REG_TRIG, {6'h00, p ^ 2'b01});
      rdv = 8'h00;
      for (int i = 0; i < 60 && rdv[7] !== 1'b1; i++) rd(REG_IDLECS, 8'h00, 8'h00);
      cmp_reg({rdv[7], 7'h00}, 8'h80);
   endtask
   task automatic conclude;
      $display("num_errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk) re_seen <= reg_re;
   always @(negedge clk) begin
      if (re_seen) begin
         e = rq.pop_front();
         if (e[15:8] != 8'h00) cmp_reg(reg_rdata & e[15:8], e[7:0]);
      end
      if (cap_ok === 1'b1) cmp_cap(cap, cq.pop_front());
   end
   initial begin
      #500000;
      num_errors++;
      conclude();
   end
   initial begin
      void'($urandom(32'h2a3a60da));
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      #1 cmp_pin(22'({pins.strobe_oe, pins.data_low_lane_oe, pins.data_high_lane_oe}), 22'hfc);
      rd(REG_IDLECS, 8'hff, 8'h80);
      rd(REG_COUNT, 8'hff, COUNT_RST);
      rd(16'h7830, 8'hff, 8'h00);
      rd(WMEM_BASE, 8'hff, 8'h00);
      wr(REG_IFCFG, 8'h04);
      rd(REG_IFCFG, 8'h04, 8'h04);
      for (int k = 0; k < 4; k++) begin
         wr(REG_OUTCFG, sm[k][27:20]);
         wr(REG_IDLEOUT, sm[k][19:12]);
         repeat (3) @(posedge clk);
         #1 cmp_pin(22'({pins.strobe_oe, pins.strobe_out & pins.strobe_oe}), 22'(sm[k][11:0]));
      end
      wr(REG_OUTCFG, 8'h00);
      wr(REG_IDLEOUT, 8'h00);
      // programs go in before any trigger; iv0 strobes and waits ready high, iv1 waits low
      for (int p = 0; p < 4; p++) begin
         pw = {32'h38040000, 32'h48050100 | (p > 1 ? 32'h00020000 : 32'h0)};
         for (int b = 0; b < 8; b++) wr(16'(WMEM_BASE + p * 32 + b), pw[8 * b +: 8]);
      end
      wr(REG_READY, 8'h40);
      for (int k = 0; k < 8; k++) begin
         base = 6'($urandom);
         wd_lo = 8'($urandom);
         wd_hi = 8'($urandom);
         rd_val = 16'($urandom);
         dly = 3'($urandom);
         wr(REG_IFCFG, {5'h00, k[2], 2'h0});
         wr(REG_ADDR, {2'h0, base});
         wr(REG_WDLO, wd_lo);
         wr(REG_WDHI, wd_hi);
         wr(REG_COUNT, k[1] ? 8'h03 : 8'h01);
         for (int i = 0; i < (k[1] ? 3 : 1); i++)
            cq.push_back({base + 6'(k[1] ? i : 0), k[0] ? {8'h00, rd_val[7:0]} : {k[2] ? wd_hi : 8'h00, wd_lo}});
         run(k[1:0]);
         if (k[0]) rd(REG_RDLO, 8'hff, rd_val[7:0]);
         if (k[0]) rd(REG_RDHI, 8'hff, k[2] ? rd_val[15:8] : 8'h00);
      end
      lat1 = lat;
      wr(REG_READY, 8'h00);
      wr(REG_ADDR, {2'h0, base});
      wr(REG_IDLECS, 8'h01);
      idrv = 1'b1;
      cq.push_back({base, wd_hi, wd_lo});
      run(2'h0);
      cmp_pin(22'(lat), 22'(lat1 + 4'h1));
      repeat (3) @(posedge clk);
      #1 cmp_pin(22'({pins.data_low_lane_oe, pins.data_low_lane_out}), {13'h0, 1'b1, wd_lo});
      wr(REG_IDLECS, 8'h00);
      idrv = 1'b0;
      repeat (3) @(posedge clk);
      #1 cmp_pin(22'(pins.data_low_lane_oe), 22'h0);
      conclude();
   end
endmodule
